//--- core/cwd_pkg.sv
// Package of constants and types for the configuration word decoder
package cwd_pkg;
  localparam int CWD_WORD_W = 14;
  localparam int CWD_NUM_WORDS = 5;
  localparam logic [CWD_WORD_W-1:0] CWD_ERASED = 14'h3fff;
  // Implemented bit masks; unimplemented bits read as one
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_OSC = 14'h2977;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_SUP = 14'h3ee3;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_WDG = 14'h3f7f;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_MEM = 14'h2b9f;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_CP = 14'h0001;
  // APB byte addresses
  localparam logic [7:0] CWD_ADDR_OSC = 8'h00;
  localparam logic [7:0] CWD_ADDR_SUP = 8'h04;
  localparam logic [7:0] CWD_ADDR_WDG = 8'h08;
  localparam logic [7:0] CWD_ADDR_MEM = 8'h0c;
  localparam logic [7:0] CWD_ADDR_CP = 8'h10;
  localparam logic [7:0] CWD_ADDR_STAT = 8'h14;
  localparam logic [7:0] CWD_ADDR_CTRL = 8'h18;
  // Field positions
  localparam int CWD_EXTOSC_LSB = 0;
  localparam int CWD_MASTER_CLEAR_PIN_ENABLE_BIT = 0;
  localparam int CWD_STKRST_BIT = 12;
  localparam int CWD_DEBUG_BIT = 13;
  localparam int CWD_WPS_LSB = 0;
  localparam int CWD_WMODE_LSB = 5;
  localparam int CWD_WWIN_LSB = 8;
  localparam int CWD_WCLK_LSB = 11;
  localparam int CWD_BOOT_REGION_SIZE_LSB = 0;
  localparam int CWD_BOOT_REGION_ENABLE_BIT = 3;
  localparam int CWD_STORAGE_FLASH_ENABLE_BIT = 4;
  localparam int CWD_APP_REGION_WRITE_LOCK_BIT = 7;
  localparam int CWD_BOOT_REGION_WRITE_LOCK_BIT = 8;
  localparam int CWD_CFG_REGION_WRITE_LOCK_BIT = 9;
  localparam int CWD_STORAGE_FLASH_WRITE_LOCK_BIT = 11;
  localparam int CWD_LVP_BIT = 13;
  localparam int CWD_CP_BIT = 0;
  // Period-select, window, boot-block, stack-depth and erase-key constants
  localparam logic [4:0] CWD_WPS_DEFAULT = 5'h1f;
  localparam logic [4:0] CWD_WPS_DEF_LOAD = 5'h0b;
  localparam logic [4:0] CWD_WPS_MAX = 5'h12;
  localparam logic [4:0] CWD_WPS_MIN = 5'h00;
  localparam logic [2:0] CWD_WIN_OPEN = 3'h7;
  localparam logic [2:0] CWD_WIN_OPEN_ALT = 3'h6;
  localparam logic [2:0] CWD_BB_SMALLEST = 3'h7;
  localparam int CWD_BB_BASE_WORDS = 512;
  localparam int CWD_STACK_DEPTH = 16;
  localparam logic [31:0] CWD_ERASE_KEY = 32'h0000_00e5;

  typedef enum logic [2:0] {
    CWD_OSC_XT = 3'h1, CWD_OSC_HS = 3'h2, CWD_OSC_RSVD = 3'h3,
    CWD_OSC_OFF = 3'h4, CWD_OSC_EC_LOW = 3'h5, CWD_OSC_EC_MID = 3'h6,
    CWD_OSC_EC_HIGH = 3'h7
  } cwd_osc_mode_t;

  typedef enum logic [1:0] {
    CWD_PWR_LOW = 2'h0, CWD_PWR_MED = 2'h1, CWD_PWR_HIGH = 2'h2
  } cwd_power_t;

  typedef enum logic [2:0] {
    CWD_WCLK_SW, CWD_WCLK_RSVD, CWD_WCLK_SECONDARY_OSC, CWD_WCLK_LFINT,
    CWD_WCLK_MFINT
  } cwd_wclk_t;

  typedef struct packed {
    logic master_clear_active;
    logic low_voltage_prog;
    logic code_protect;
    logic [2:0] ext_osc_mode;
    logic [1:0] ext_osc_power;
    logic ext_osc_enable;
    logic [2:0] wdog_clock;
    logic [2:0] wdog_window;
    logic wdog_window_soft;
    logic wdog_keyed;
    logic wdog_run;
    logic [4:0] wdog_period;
    logic wdog_period_soft;
    logic [12:0] boot_size;
    logic boot_lock;
    logic app_lock;
    logic cfg_lock;
    logic saf_enable;
    logic saf_lock;
    logic stack_fault_reset;
    logic debug_enable;
  } cwd_cfg_t;

  // Memory port toward external programmer
  typedef struct packed {
    logic req;
    logic wr;
    logic [14:0] addr;
    logic [13:0] wdata;
  } cwd_ext_req_t;

  typedef struct packed {
    logic ack;
    logic [13:0] rdata;
  } cwd_ext_rsp_t;
endpackage

//--- core/cwd_stack.sv
// Sixteen-level return stack with overflow and underflow handling
module cwd_stack
  import cwd_pkg::*;
#(
  parameter int DEPTH = cwd_pkg::CWD_STACK_DEPTH,
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic fault_reset_en,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  // Status
  output logic [WIDTH-1:0] top,
  output logic overflow,
  output logic underflow,
  output logic fault_reset
);
  import cwd_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] count;
    logic [PW-1:0] ptr;
    logic ovf;
    logic unf;
    logic rst;
  } cwd_stk_state_t;

  cwd_stk_state_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;

  assign full = (st_reg.count == (PW+1)'(DEPTH));
  assign empty = (st_reg.count == '0);

  always_comb begin
    st_next = st_reg;
    st_next.rst = 1'b0;
    if (push && !pop) begin
      if (full) begin
        st_next.ovf = 1'b1;
        st_next.rst = fault_reset_en;
        if (!fault_reset_en) begin
          st_next.ptr = st_reg.ptr + 1'b1;
        end
      end else begin
        st_next.count = st_reg.count + 1'b1;
        st_next.ptr = st_reg.ptr + 1'b1;
      end
    end else if (pop && !push) begin
      if (empty) begin
        st_next.unf = 1'b1;
        st_next.rst = fault_reset_en;
      end else begin
        st_next.count = st_reg.count - 1'b1;
        st_next.ptr = st_reg.ptr - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (push && !pop && !(full && fault_reset_en)) begin
      mem[PW'(st_reg.ptr + 1'b1)] <= push_data;
    end
  end

  assign top = mem[st_reg.ptr];
  assign overflow = st_reg.ovf;
  assign underflow = st_reg.unf;
  assign fault_reset = st_reg.rst;

  a_stack_ovf_rst: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !pop && full && fault_reset_en) |=> (fault_reset && overflow))
    else $error("overflow did not reset");
  a_stack_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !pop && full && !fault_reset_en) |=> (!fault_reset && overflow))
    else $error("circular push misbehaved");
endmodule // cwd_stack

//--- core/cwd_decoder.sv
// Configuration word decoder with APB access and protection gating
//
// Implementation choices: the register offsets and the APB register port.
module cwd_decoder
  import cwd_pkg::*;
#(
  parameter int PROG_WORDS = 8192
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile word source
  input wire logic [CWD_NUM_WORDS*CWD_WORD_W-1:0] nvm_words,
  // Pin and core inputs
  input wire logic reset_program_pin,
  input wire logic sleep_active,
  input wire logic wdog_soft_enable,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [14:0] stack_push_data,
  // External programmer port
  input wire cwd_pkg::cwd_ext_req_t ext_req,
  output cwd_pkg::cwd_ext_rsp_t ext_rsp,
  // Internal memory side of the external port
  input wire logic [13:0] mem_rdata,
  output logic mem_wr,
  output logic [14:0] mem_addr,
  output logic [13:0] mem_wdata,
  // Decoded settings
  output cwd_pkg::cwd_cfg_t cfg,
  output logic master_clear_reset,
  output logic general_input,
  output logic wdog_enable,
  output logic stack_fault_rst,
  output logic [14:0] stack_top
);
  import cwd_pkg::*;

  localparam int W = CWD_WORD_W;
  localparam logic [12:0] HALF_WORDS = 13'(PROG_WORDS / 2);

  typedef enum {ST_LOAD, ST_RUN} cwd_phase_t;

  typedef struct packed {
    cwd_phase_t phase;
    logic [4:0][W-1:0] words;
    logic [4:0][W-1:0] ld_words;
    cwd_cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic master_clear_pin_rst;
    logic gen_in;
    logic wdog_en;
    logic stk_rst;
    logic [14:0] stk_top;
    cwd_ext_rsp_t ext_rsp;
    logic mem_wr;
    logic [14:0] mem_addr;
    logic [13:0] mem_wdata;
    logic pin_s1;
    logic pin_s2;
  } cwd_state_t;

  cwd_state_t s_reg, s_next;
  logic [14:0] stk_top_w;
  logic stk_ovf, stk_unf, stk_rst_w;

  function automatic logic [12:0] boot_words(input logic en_n,
                                             input logic [2:0] code);
    logic [12:0] size;
    size = '0;
    if (!en_n) begin
      size = 13'(CWD_BB_BASE_WORDS) << (CWD_BB_SMALLEST - code);
      if (code < 3'h4 || size > HALF_WORDS) begin
        size = HALF_WORDS;
      end
    end
    return size;
  endfunction

  function automatic logic [W-1:0] fix_word(input logic [W-1:0] raw,
                                            input logic [W-1:0] mask);
    return raw | ~mask;
  endfunction

  function automatic logic [31:0] word_out(input logic [W-1:0] w);
    return {18'h0, w};
  endfunction

  function automatic cwd_cfg_t decode(input logic [4:0][W-1:0] wd);
    cwd_cfg_t c;
    logic [2:0] osc, wclk, wwin;
    logic [1:0] wmode;
    logic [4:0] wps;
    c = '0;
    osc = wd[0][CWD_EXTOSC_LSB +: 3];
    c.ext_osc_mode = osc;
    c.ext_osc_enable = (osc != CWD_OSC_OFF) && (osc != CWD_OSC_RSVD);
    case (osc)
      CWD_OSC_EC_HIGH, CWD_OSC_HS: c.ext_osc_power = CWD_PWR_HIGH;
      CWD_OSC_EC_MID, CWD_OSC_XT: c.ext_osc_power = CWD_PWR_MED;
      default: c.ext_osc_power = CWD_PWR_LOW;
    endcase
    c.low_voltage_prog = wd[3][CWD_LVP_BIT];
    c.master_clear_active = wd[3][CWD_LVP_BIT] ||
                            wd[1][CWD_MASTER_CLEAR_PIN_ENABLE_BIT];
    c.stack_fault_reset = wd[1][CWD_STKRST_BIT];
    c.debug_enable = !wd[1][CWD_DEBUG_BIT];
    wclk = wd[2][CWD_WCLK_LSB +: 3];
    case (wclk)
      3'h7: c.wdog_clock = CWD_WCLK_SW;
      3'h2: c.wdog_clock = CWD_WCLK_SECONDARY_OSC;
      3'h1: c.wdog_clock = CWD_WCLK_LFINT;
      3'h0: c.wdog_clock = CWD_WCLK_MFINT;
      default: c.wdog_clock = CWD_WCLK_RSVD;
    endcase
    wwin = wd[2][CWD_WWIN_LSB +: 3];
    if (wwin == CWD_WIN_OPEN || wwin == CWD_WIN_OPEN_ALT) begin
      c.wdog_window = CWD_WIN_OPEN;
      c.wdog_window_soft = 1'b1;
      c.wdog_keyed = 1'b0;
    end else begin
      c.wdog_window = wwin;
      c.wdog_window_soft = 1'b0;
      c.wdog_keyed = 1'b1;
    end
    wmode = wd[2][CWD_WMODE_LSB +: 2];
    c.wdog_run = wmode[1];
    wps = wd[2][CWD_WPS_LSB +: 5];
    if (wps == CWD_WPS_DEFAULT) begin
      c.wdog_period = CWD_WPS_DEF_LOAD;
      c.wdog_period_soft = 1'b1;
    end else if (wps > CWD_WPS_MAX) begin
      c.wdog_period = CWD_WPS_MIN;
    end else begin
      c.wdog_period = wps;
    end
    c.boot_size = boot_words(wd[3][CWD_BOOT_REGION_ENABLE_BIT],
                             wd[3][CWD_BOOT_REGION_SIZE_LSB +: 3]);
    c.boot_lock = !wd[3][CWD_BOOT_REGION_WRITE_LOCK_BIT] && !wd[3][CWD_BOOT_REGION_ENABLE_BIT];
    c.app_lock = !wd[3][CWD_APP_REGION_WRITE_LOCK_BIT];
    c.cfg_lock = !wd[3][CWD_CFG_REGION_WRITE_LOCK_BIT];
    c.saf_enable = !wd[3][CWD_STORAGE_FLASH_ENABLE_BIT];
    c.saf_lock = c.saf_enable && !wd[3][CWD_STORAGE_FLASH_WRITE_LOCK_BIT];
    c.code_protect = !wd[4][CWD_CP_BIT];
    return c;
  endfunction

  cwd_stack #(.DEPTH(CWD_STACK_DEPTH), .WIDTH(15)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .fault_reset_en(s_reg.cfg.stack_fault_reset),
    .push(stack_push),
    .pop(stack_pop),
    .push_data(stack_push_data),
    .top(stk_top_w),
    .overflow(stk_ovf),
    .underflow(stk_unf),
    .fault_reset(stk_rst_w)
  );

  always_comb begin
    logic apb_setup;
    logic apb_commit;
    logic [W-1:0] wv;
    apb_setup = psel && !penable;
    // Write lands at the edge where pready is seen high
    apb_commit = psel && penable && pwrite && s_reg.pready;
    wv = '0;
    s_next = s_reg;
    s_next.pin_s1 = reset_program_pin;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.mem_wr = 1'b0;
    s_next.ext_rsp.ack = 1'b0;
    s_next.stk_top = stk_top_w;
    s_next.stk_rst = stk_rst_w;
    case (s_reg.phase)
      ST_LOAD: begin
        // Capture words once after reset release
        s_next.words[0] = fix_word(nvm_words[0*W +: W], CWD_MASK_OSC);
        s_next.words[1] = fix_word(nvm_words[1*W +: W], CWD_MASK_SUP);
        s_next.words[2] = fix_word(nvm_words[2*W +: W], CWD_MASK_WDG);
        s_next.words[3] = fix_word(nvm_words[3*W +: W], CWD_MASK_MEM);
        s_next.words[4] = fix_word(nvm_words[4*W +: W], CWD_MASK_CP);
        s_next.cfg = decode(s_next.words);
        s_next.ld_words = s_next.words;
        s_next.phase = ST_RUN;
      end
      ST_RUN: begin
        s_next.master_clear_pin_rst = s_reg.cfg.master_clear_active &&
                          !s_reg.pin_s2;
        s_next.gen_in = !s_reg.cfg.master_clear_active &&
                        s_reg.pin_s2;
        case (s_reg.ld_words[2][CWD_WMODE_LSB +: 2])
          2'b11: s_next.wdog_en = 1'b1;
          2'b10: s_next.wdog_en = !sleep_active;
          2'b01: s_next.wdog_en = wdog_soft_enable;
          default: s_next.wdog_en = 1'b0;
        endcase
        if (ext_req.req) begin
          s_next.ext_rsp.ack = 1'b1;
          s_next.mem_addr = ext_req.addr;
          if (s_reg.cfg.code_protect) begin
            s_next.ext_rsp.rdata = '0;
          end else if (ext_req.wr) begin
            s_next.mem_wr = 1'b1;
            s_next.mem_wdata = ext_req.wdata;
          end else begin
            s_next.ext_rsp.rdata = mem_rdata;
          end
        end
        if (apb_setup) begin
          s_next.pready = 1'b1;
          if (pwrite) begin
            s_next.pslverr = (paddr != CWD_ADDR_MEM) &&
                             (paddr != CWD_ADDR_CTRL);
          end else begin
            case (paddr)
              CWD_ADDR_OSC: s_next.prdata = word_out(s_reg.words[0]);
              CWD_ADDR_SUP: s_next.prdata = word_out(s_reg.words[1]);
              CWD_ADDR_WDG: s_next.prdata = word_out(s_reg.words[2]);
              CWD_ADDR_MEM: s_next.prdata = word_out(s_reg.words[3]);
              CWD_ADDR_CP: s_next.prdata = word_out(s_reg.words[4]);
              CWD_ADDR_STAT: s_next.prdata = {29'h0, stk_unf, stk_ovf,
                                              s_reg.master_clear_pin_rst};
              CWD_ADDR_CTRL: s_next.prdata = '0;
              default: begin
                s_next.prdata = '0;
                s_next.pslverr = 1'b1;
              end
            endcase
          end
        end
        if (apb_commit) begin
          if (paddr == CWD_ADDR_MEM) begin
            // Lock bits only clear to zero; ones return only on the CTRL erase key
            wv = s_reg.words[3] & fix_word(pwdata[W-1:0],
                                            CWD_MASK_MEM);
            s_next.words[3] = wv;
          end else if (paddr == CWD_ADDR_CTRL &&
                       pwdata == CWD_ERASE_KEY) begin
            s_next.words = {5{CWD_ERASED}};
          end
        end
      end
      default: s_next.phase = ST_LOAD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      // Pin idles high; avoids a false master clear after reset
      s_reg.pin_s1 <= 1'b1;
      s_reg.pin_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign ext_rsp = s_reg.ext_rsp;
  assign mem_wr = s_reg.mem_wr;
  assign mem_addr = s_reg.mem_addr;
  assign mem_wdata = s_reg.mem_wdata;
  assign cfg = s_reg.cfg;
  assign master_clear_reset = s_reg.master_clear_pin_rst;
  assign general_input = s_reg.gen_in;
  assign wdog_enable = s_reg.wdog_en;
  assign stack_fault_rst = s_reg.stk_rst;
  assign stack_top = s_reg.stk_top;

  sequence seq_prot_req;
    s_reg.phase == ST_RUN && ext_req.req && s_reg.cfg.code_protect;
  endsequence

  a_cp_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    seq_prot_req |=> (ext_rsp.ack && ext_rsp.rdata == '0 && !mem_wr))
    else $error("protected access leaked");
  a_cp_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.phase == ST_RUN |-> cfg.code_protect == !s_reg.ld_words[4][0])
    else $error("code protect polarity wrong");
  a_master_clear_pin_lvp: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.phase == ST_RUN && s_reg.ld_words[3][CWD_LVP_BIT])
      |-> cfg.master_clear_active)
    else $error("low voltage mode lost master clear");
  a_master_clear_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.phase == ST_RUN && cfg.master_clear_active && !s_reg.pin_s2)
      |=> master_clear_reset)
    else $error("master clear did not reset");
  a_cfg_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $past(s_reg.phase == ST_RUN) |-> $stable(cfg))
    else $error("config changed after load");
  a_wps_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.phase == ST_RUN |-> (cfg.wdog_period <= CWD_WPS_MAX))
    else $error("period out of range");
  a_wps_default: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.phase == ST_RUN && cfg.wdog_period_soft)
      |-> cfg.wdog_period == CWD_WPS_DEF_LOAD)
    else $error("default period wrong");
  a_boot_half: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.phase == ST_RUN |-> cfg.boot_size <= HALF_WORDS)
    else $error("boot block above half");
  a_win_keyed: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.phase == ST_RUN |-> cfg.wdog_keyed == !cfg.wdog_window_soft)
    else $error("window key mismatch");
  a_wdog_off: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.phase == ST_RUN && s_reg.ld_words[2][6:5] == 2'b00)
      |=> !wdog_enable)
    else $error("watchdog ran while disabled");
  a_sticky_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.phase == ST_RUN && !s_reg.words[3][CWD_APP_REGION_WRITE_LOCK_BIT]
      && !(psel && penable && s_reg.pready && pwrite
           && paddr == CWD_ADDR_CTRL))
      |=> !s_reg.words[3][CWD_APP_REGION_WRITE_LOCK_BIT])
    else $error("sticky lock cleared");
endmodule // cwd_decoder

//--- testbench/cwd_decoder_tb.sv
// Self-checking bench for the configuration word decoder
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module cwd_decoder_tb;
  import cwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] MSK [5] = '{CWD_MASK_OSC, CWD_MASK_SUP,
    CWD_MASK_WDG, CWD_MASK_MEM, CWD_MASK_CP};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic reset_program_pin, sleep_active, wdog_soft_enable;
  logic stack_push, stack_pop, mem_wr, master_clear_reset, general_input;
  logic wdog_enable, stack_fault_rst;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, s;
  logic [69:0] nvm;
  logic [95:0] t;
  logic [13:0] mem_rdata, mem_wdata, xr;
  logic [13:0] w [5];
  logic [14:0] stack_push_data, mem_addr, stack_top;
  cwd_ext_req_t ext_req;
  cwd_ext_rsp_t ext_rsp;
  cwd_cfg_t cfg, snap;
  int mismatches, num_checks, wr_cnt, fr_cnt, n;

  cwd_decoder #(.PROG_WORDS(4096)) cwd_decoder_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nvm_words(nvm), .reset_program_pin(reset_program_pin),
    .sleep_active(sleep_active), .wdog_soft_enable(wdog_soft_enable),
    .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_push_data(stack_push_data), .ext_req(ext_req), .ext_rsp(ext_rsp),
    .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .cfg(cfg), .master_clear_reset(master_clear_reset),
    .general_input(general_input), .wdog_enable(wdog_enable),
    .stack_fault_rst(stack_fault_rst), .stack_top(stack_top));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (mem_wr === 1'b1) wr_cnt++;
    if (stack_fault_rst === 1'b1) fr_cnt++;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [4:0] exp_wps(input logic [4:0] p);
    if (p == 5'h1f) return 5'h0b;
    return (p > 5'h12) ? 5'h00 : p;
  endfunction

  function automatic logic [2:0] exp_wclk(input logic [2:0] c);
    case (c)
      3'h7: return CWD_WCLK_SW;
      3'h6: return CWD_WCLK_RSVD;
      3'h2: return CWD_WCLK_SECONDARY_OSC;
      3'h1: return CWD_WCLK_LFINT;
      default: return CWD_WCLK_MFINT;
    endcase
  endfunction

  function automatic logic exp_wden(input logic [1:0] m, input logic sl, sw);
    case (m)
      2'b11: return 1'b1;
      2'b10: return ~sl;
      2'b01: return sw;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [12:0] exp_boot(input logic en_n, logic [2:0] c);
    int bs;
    bs = (c < 3'h4) ? 2048 : (512 << (7 - c));
    if (bs > 2048) bs = 2048;
    return en_n ? 13'h0 : 13'(bs);
  endfunction

  task automatic apb(input logic wr_i, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_i;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic ext(input logic wr_i, input logic [14:0] a);
    int k;
    k = 0;
    ext_req <= '{1'b1, wr_i, a, 14'h0155};
    @(posedge pclk);
    ext_req.req <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (ext_rsp.ack !== 1'b1 && k < 8);
    if (k >= 8) mismatches++;
    xr = ext_rsp.rdata;
    `CHK("ext_addr", a, mem_addr)
    @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // One load from reset and the checks that follow it
  // ************************************************************
  task automatic round(input logic [69:0] v);
    logic [13:0] d;
    logic mca;
    for (int k = 0; k < 5; k++) w[k] = v[14*k +: 14];
    mca = w[3][13] | w[1][0];
    nvm <= v;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    snap = cfg;
    nvm <= ~v;
    `CHK("master_clear_pin_act", mca, cfg.master_clear_active)
    `CHK("lvp", w[3][13], cfg.low_voltage_prog)
    `CHK("cp", ~w[4][0], cfg.code_protect)
    `CHK("wps", exp_wps(w[2][4:0]), cfg.wdog_period)
    `CHK("wps_sw", w[2][4:0] == 5'h1f, cfg.wdog_period_soft)
    d[2:0] = (w[2][10:8] == 3'h6) ? 3'h7 : w[2][10:8];
    `CHK("win", d[2:0], cfg.wdog_window)
    `CHK("win_sw", w[2][10:9] == 2'b11, cfg.wdog_window_soft)
    `CHK("keyed", w[2][10:9] != 2'b11, cfg.wdog_keyed)
    if (w[2][13:11] inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7})
      `CHK("wclk", exp_wclk(w[2][13:11]), cfg.wdog_clock)
    if (w[0][2:0] != 3'h0)
      `CHK("osc", w[0][2:0], cfg.ext_osc_mode)
    `CHK("boot", exp_boot(w[3][3], w[3][2:0]), cfg.boot_size)
    `CHK("saf", ~w[3][4], cfg.saf_enable)
    `CHK("stk", w[1][12], cfg.stack_fault_reset)
    `CHK("osc_en", !(w[0][2:0] inside {3'h3, 3'h4}), cfg.ext_osc_enable)
    `CHK("dbg", ~w[1][13], cfg.debug_enable)
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      `CHK("word", {18'h0, w[k] | ~MSK[k]}, rd)
      `CHK("rd_err", 1'b0, e)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {e, rd})
    apb(1'b1, CWD_ADDR_OSC, rnd());
    `CHK("ro_err", 1'b1, e)
    d = 14'(rnd());
    apb(1'b1, CWD_ADDR_MEM, {18'h0, d});
    apb(1'b1, CWD_ADDR_MEM, 32'h0000_3fff);
    apb(1'b0, CWD_ADDR_MEM, 32'h0);
    `CHK("sticky", {18'h0, (w[3] & d) | ~MSK[3]}, rd)
    mem_rdata <= 14'(rnd());
    ext(1'b0, 15'(rnd()));
    `CHK("ext_rd", w[4][0] ? mem_rdata : 14'h0, xr)
    n = wr_cnt;
    ext(1'b1, 15'(rnd()));
    `CHK("ext_wr", 32'(w[4][0]), 32'(wr_cnt - n))
    if (w[4][0])
      `CHK("ext_wdata", 14'h0155, mem_wdata)
    for (int i = 0; i < 4; i++) begin
      sleep_active <= i[0];
      wdog_soft_enable <= i[1];
      repeat (3) @(posedge pclk);
      `CHK("wden", exp_wden(w[2][6:5], i[0], i[1]), wdog_enable)
    end
    n = fr_cnt;
    for (int k = 1; k <= 17; k++) begin
      stack_push <= 1'b1;
      stack_push_data <= 15'(k);
      @(posedge pclk);
    end
    stack_push <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("fault_rst", 32'(w[1][12]), 32'(fr_cnt - n))
    if (!w[1][12])
      `CHK("wrap_top", 15'd17, stack_top)
    reset_program_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("master_clear_pin_rst", mca, master_clear_reset)
    apb(1'b0, CWD_ADDR_STAT, 32'h0);
    `CHK("stat", {1'b1, mca}, rd[1:0])
    reset_program_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("master_clear_pin_off", 1'b0, master_clear_reset)
    `CHK("gen_in", ~mca, general_input)
    apb(1'b1, CWD_ADDR_CTRL, CWD_ERASE_KEY);
    apb(1'b0, CWD_ADDR_WDG, 32'h0);
    `CHK("erased", 32'h0000_3fff, rd)
    `CHK("cfg_hold", snap, cfg)
  endtask

  initial begin
    s = 32'd15404;
    presetn = 1'b0;
    {psel, penable, pwrite, stack_push, stack_pop} = '0;
    {sleep_active, wdog_soft_enable} = '0;
    reset_program_pin = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    nvm = '1;
    mem_rdata = 14'h0;
    stack_push_data = 15'h0;
    ext_req = '0;
    round({70{1'b1}});
    round({14'h3ffe, 14'h1ff4, 14'h16b2, 14'h2ffe, 14'h3fff});
    round({14'h3fff, 14'h3ff7, 14'h08d3, 14'h3fff, 14'h3ffa});
    for (int r = 0; r < 6; r++) begin
      t = {rnd(), rnd(), rnd()};
      round(t[69:0]);
    end
    wrap_up();
  end

  initial begin
    #2_000_000;
    mismatches++;
    wrap_up();
  end
endmodule // cwd_decoder_tb
